// [hdl/pasc_pkg.sv]
// Package for the PHY auto-negotiation status and configuration register set.
// Assumes a 250 MHz system clock and 16-bit management register words.
package pasc_pkg;

    localparam logic [4:0]  ADDR_PARTNER   = 5'h05;
    localparam logic [4:0]  ADDR_EXPANSION = 5'h06;
    localparam logic [4:0]  ADDR_CONFIG    = 5'h10;

    localparam int PA_NEXT_PAGE   = 15;
    localparam int PA_ACK         = 14;
    localparam int PA_REMOTE_FLT  = 13;
    localparam int PA_ABIL_LSB    = 5;
    localparam int PA_ABIL_MSB    = 9;
    localparam int PA_SEL_MSB     = 4;

    localparam int EX_PD_FAULT    = 4;
    localparam int EX_LP_NP       = 3;
    localparam int EX_LOC_NP      = 2;
    localparam int EX_PAGE_RX     = 1;
    localparam int EX_LP_AN       = 0;

    localparam int CF_FORCE_LINK  = 7;
    localparam int CF_FSM_RESET   = 3;
    localparam int CF_PRE_SKIP    = 2;
    localparam int CF_SLEEP       = 1;
    localparam int CF_LOOP_OUT    = 0;

    localparam logic [15:0] CFG_WRITE_MASK = 16'h008F;
    localparam logic [15:0] RESET_WORD     = 16'h0000;
    localparam logic        LOCAL_LOCAL_NEXT_PAGE_CAPABLE  = 1'b0;

    // Length of the state machine reset pulse.
    localparam int FSM_RST_NS     = 40;
    localparam int CLK_PERIOD_NS  = 4;
    localparam int FSM_RST_CYC    = (FSM_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic        valid;
        logic        next_page;
        logic        ack;
        logic        remote_fault;
        logic [4:0]  abilities;
        logic [4:0]  selector;
    } pasc_page_s;

    typedef struct packed {
        logic        req;
        logic        write;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } pasc_mgmt_s;

    typedef enum logic [1:0] {
        FSM_RUN,
        FSM_RST_ACTIVE
    } pasc_rst_e;

endpackage

// [hdl/pasc_page_capture.sv]
// Captures a received link code word once it has been seen consistently.
// Assumes the negotiation logic presents each decoded word with a valid strobe.
`timescale 1ns/10ps
module pasc_page_capture (
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst_n,
    input  wire logic              i_clear,
    input  wire pasc_pkg::pasc_page_s i_page,
    output logic [15:0]            o_partner_word,
    output logic                   o_new_page
);
    import pasc_pkg::*;

    logic [15:0] last_word_reg;
    logic [15:0] held_word_reg;
    logic        seen_once_reg;
    logic [15:0] rx_word;
    logic        consistent;

    // The reserved field 12..10 is forced to zero here.
    assign rx_word = {i_page.next_page, i_page.ack, i_page.remote_fault,
                      3'h0, i_page.abilities, i_page.selector};
    assign consistent = i_page.valid && seen_once_reg && (rx_word == last_word_reg);

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            last_word_reg <= RESET_WORD;
            held_word_reg <= RESET_WORD;
            seen_once_reg <= 1'b0;
            o_new_page    <= 1'b0;
        end else if (i_clear) begin
            last_word_reg <= RESET_WORD;
            held_word_reg <= RESET_WORD;
            seen_once_reg <= 1'b0;
            o_new_page    <= 1'b0;
        end else begin
            o_new_page <= consistent && (rx_word != held_word_reg || !seen_once_reg);
            if (i_page.valid) begin
                last_word_reg <= rx_word;
                seen_once_reg <= 1'b1;
            end
            if (consistent) begin
                held_word_reg <= rx_word;
            end
        end
    end

    assign o_partner_word = held_word_reg;

    pair_word_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        consistent && !i_clear |=> o_partner_word == $past(rx_word))
        else $error("Partner word not captured after consistent page.");
endmodule

// [hdl/pasc_fsm_reset.sv]
// Stretches a state machine reset request into a fixed-length pulse.
// Assumes requests are single-cycle pulses from the register logic.
`timescale 1ns/10ps
module pasc_fsm_reset (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    input  wire logic i_start,
    output logic      o_busy,
    output logic      o_done
);
    import pasc_pkg::*;

    pasc_rst_e   state_reg;
    logic [7:0]  count_reg;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= FSM_RUN;
            count_reg <= 8'h00;
            o_done    <= 1'b0;
        end else begin
            o_done <= 1'b0;
            unique case (state_reg)
                FSM_RUN: begin
                    if (i_start) begin
                        state_reg <= FSM_RST_ACTIVE;
                        count_reg <= 8'(FSM_RST_CYC - 1);
                    end
                end
                FSM_RST_ACTIVE: begin
                    if (count_reg == 8'h00) begin
                        state_reg <= FSM_RUN;
                        o_done    <= 1'b1;
                    end else begin
                        count_reg <= count_reg - 8'h01;
                    end
                end
                default: state_reg <= FSM_RUN;
            endcase
        end
    end

    assign o_busy = (state_reg == FSM_RST_ACTIVE);

    rst_length_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        $rose(o_busy) |-> o_busy [*8] ##1 o_busy [*2] ##1 (!o_busy && o_done))
        else $error("State machine reset pulse has the wrong length.");
endmodule

// [hdl/pasc_regs.sv]
// Management register set: partner ability, expansion and vendor configuration.
// Assumes a management frame engine issues one-cycle read and write requests.
// Notes on behaviour
// - Received partner abilities are captured into the read-only register at address 5.
// - Bit 15 shows partner next page availability; resets to zero.
// - Acknowledge bit 14 comes only from negotiation logic; software never writes it.
// - Bit 13 shows partner remote fault; resets to zero.
// - Bits 9..5 show partner T4, TX full, TX half, 10 full, 10 half.
// - Bits 4..0 hold partner selector field, reset to zero.
// - Reserved bits of registers 5 and 6 read zero; writes ignored.
// - Expansion bit 4 latches high on a parallel detection fault.
// - Expansion bit 3 shows partner next page ability.
// - Expansion bit 2 always reads zero; no local next page.
// - Expansion bit 1 latches on new page, clears when register 6 is read.
// - Expansion bit 0 shows partner auto-negotiation ability.
// - Configuration bit 7 forces good link at 100 Mbit/s; resets to zero.
// - Writing configuration bit 3 resets PHY state machines; bit self-clears after.
// - Configuration bit 2 enables management preamble suppression; resets off.
// - Clearing sleep keeps configuration and resets state machines.
// - Configuration bit 0 loops received data out to transmit.
`timescale 1ns/10ps
module pasc_regs (
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_reset_n,
    input  wire pasc_pkg::pasc_mgmt_s i_mgmt,
    output logic [15:0]               o_rdata,
    output logic                      o_rvalid,
    input  wire pasc_pkg::pasc_page_s i_page,
    input  wire logic                 i_neg_restart,
    input  wire logic                 i_pd_fault,
    input  wire logic                 i_partner_an_able,
    output logic                      o_force_link_100,
    output logic                      o_preamble_skip,
    output logic                      o_sleep,
    output logic                      o_remote_loopback,
    output logic                      o_fsm_reset
);
    import pasc_pkg::*;

    logic        rst_sync1_reg;
    logic        rst_sync2_reg;
    logic        rst_n;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_sync2_reg <= rst_sync1_reg;
        end
    end
    assign rst_n = rst_sync2_reg;

    // Decode of management requests.
    logic wr_cfg;
    logic rd_exp;
    logic rd_any;
    assign wr_cfg = i_mgmt.req && i_mgmt.write && (i_mgmt.addr == ADDR_CONFIG);
    assign rd_exp = i_mgmt.req && !i_mgmt.write && (i_mgmt.addr == ADDR_EXPANSION);
    assign rd_any = i_mgmt.req && !i_mgmt.write;

    // Configuration register.
    logic [15:0] cfg_reg;
    logic [15:0] cfg_next;
    logic        rst_busy;
    logic        rst_done;
    logic        sleep_exit;
    logic        rst_start;
    logic [15:0] cfg_written;

    // Writes touch only implemented bits, so reserved bits stay zero.
    assign cfg_written = i_mgmt.wdata & CFG_WRITE_MASK;
    assign sleep_exit  = wr_cfg && cfg_reg[CF_SLEEP] && !i_mgmt.wdata[CF_SLEEP];
    assign rst_start   = (wr_cfg && i_mgmt.wdata[CF_FSM_RESET]) || sleep_exit;

    always_comb begin
        cfg_next = cfg_reg;
        if (wr_cfg) begin
            cfg_next = cfg_written;
            // Reset bit stays set until the pulse ends, even if written 0 meanwhile.
            cfg_next[CF_FSM_RESET] = i_mgmt.wdata[CF_FSM_RESET] | cfg_reg[CF_FSM_RESET];
        end
        // A request that lands on the done pulse starts a fresh pulse, so the bit stays set.
        if (rst_done && !rst_start) begin
            cfg_next[CF_FSM_RESET] = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg <= RESET_WORD;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    pasc_fsm_reset u_fsm_reset (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (rst_n),
        .i_start   (rst_start),
        .o_busy    (rst_busy),
        .o_done    (rst_done)
    );

    assign o_force_link_100  = cfg_reg[CF_FORCE_LINK];
    assign o_preamble_skip   = cfg_reg[CF_PRE_SKIP];
    assign o_sleep           = cfg_reg[CF_SLEEP];
    assign o_remote_loopback = cfg_reg[CF_LOOP_OUT];
    assign o_fsm_reset       = rst_busy;

    // Partner ability capture; cleared on renegotiation or state machine reset.
    logic [15:0] partner_word;
    logic        new_page;
    logic        cap_clear;
    assign cap_clear = i_neg_restart || rst_busy;

    pasc_page_capture u_capture (
        .i_clk_sys      (i_clk_sys),
        .i_rst_n        (rst_n),
        .i_clear        (cap_clear),
        .i_page         (i_page),
        .o_partner_word (partner_word),
        .o_new_page     (new_page)
    );

    // Expansion register latched bits; a new event wins over the read clear.
    logic pd_fault_reg;
    logic page_rx_reg;
    logic an_able_reg;
    logic pd_fault_next;
    logic page_rx_next;
    logic an_able_next;

    assign pd_fault_next = i_pd_fault | (pd_fault_reg & ~rd_exp);
    assign page_rx_next  = new_page | (page_rx_reg & ~rd_exp);
    assign an_able_next  = cap_clear ? 1'b0 : (an_able_reg | i_partner_an_able);

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pd_fault_reg <= 1'b0;
            page_rx_reg  <= 1'b0;
            an_able_reg  <= 1'b0;
        end else begin
            pd_fault_reg <= pd_fault_next;
            page_rx_reg  <= page_rx_next;
            an_able_reg  <= an_able_next;
        end
    end

    logic [15:0] exp_word;
    assign exp_word = {11'h000, pd_fault_reg, partner_word[PA_NEXT_PAGE],
                       LOCAL_LOCAL_NEXT_PAGE_CAPABLE, page_rx_reg, an_able_reg};

    // Read mux; unmapped addresses answer zero.
    logic [15:0] rd_mux;
    assign rd_mux = (i_mgmt.addr == ADDR_PARTNER)   ? partner_word :
                    (i_mgmt.addr == ADDR_EXPANSION) ? exp_word :
                    (i_mgmt.addr == ADDR_CONFIG)    ? cfg_reg :
                    16'h0000;

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_rdata  <= 16'h0000;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= rd_any;
            if (rd_any) begin
                o_rdata <= rd_mux;
            end
        end
    end

    sequence exp_read_s;
        rd_exp && !new_page;
    endsequence

    page_rx_clear_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        exp_read_s |=> !page_rx_reg)
        else $error("New page flag not cleared by expansion read.");

    page_rx_set_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        new_page |=> page_rx_reg)
        else $error("New page flag not set.");

    pd_fault_hold_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        pd_fault_reg && !rd_exp |=> pd_fault_reg)
        else $error("Parallel fault flag dropped without a read.");

    exp_zero_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        o_rvalid && $past(i_mgmt.addr) == ADDR_EXPANSION |-> o_rdata[15:5] == 11'h000
            && o_rdata[EX_LOC_NP] == 1'b0)
        else $error("Expansion reserved or local next page bit nonzero.");

    cfg_reserved_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        (cfg_reg & ~CFG_WRITE_MASK) == 16'h0000)
        else $error("Reserved configuration bits set.");

    rst_self_clr_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        wr_cfg && i_mgmt.wdata[CF_FSM_RESET] && !cfg_reg[CF_FSM_RESET]
            |=> cfg_reg[CF_FSM_RESET] && o_fsm_reset ##[8:20] !cfg_reg[CF_FSM_RESET])
        else $error("State machine reset bit did not self-clear.");

    wake_reset_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        sleep_exit |=> o_fsm_reset && !o_sleep
            && o_force_link_100 == $past(i_mgmt.wdata[CF_FORCE_LINK]))
        else $error("Wake from sleep did not reset state machines.");

    loop_follow_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        wr_cfg |=> o_remote_loopback == $past(i_mgmt.wdata[CF_LOOP_OUT]))
        else $error("Loop out control not written.");

    partner_hold_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        !i_page.valid && !cap_clear |=> partner_word == $past(partner_word))
        else $error("Partner fields changed without a received page.");
endmodule

// [tb/pasc_sme_model.sv]
// Station management model that issues one-cycle register requests.
// Assumes it is called only after the register set has left reset.
`timescale 1ns/10ps
module pasc_sme_model (
    input  wire logic         i_clk_sys,
    input  wire logic [15:0]  i_rdata,
    input  wire logic         i_rvalid,
    output pasc_pkg::pasc_mgmt_s o_mgmt
);
    import pasc_pkg::*;

    initial o_mgmt = '0;

    // A released request shows inverted qualifiers so stale values never look valid.
    task automatic drop();
        o_mgmt <= '{1'b0, ~o_mgmt.write, ~o_mgmt.addr, ~o_mgmt.wdata};
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        o_mgmt <= '{1'b1, 1'b1, a, d};
        @(posedge i_clk_sys);
        drop();
    endtask

    task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
        @(posedge i_clk_sys);
        o_mgmt <= '{1'b1, 1'b0, a, 16'h0000};
        @(posedge i_clk_sys);
        drop();
        #1;
        ok = i_rvalid;
        d = i_rdata;
    endtask
endmodule

// [tb/pasc_regs_tb.sv]
// Self-checking bench for the PHY management register set.
// Assumes the management model and the design sit on one 250 MHz clock.
`timescale 1ns/10ps
module pasc_regs_tb;
    import pasc_pkg::*;

    logic        i_clk_sys   = 1'b0;
    logic        i_reset_n   = 1'b0;
    pasc_mgmt_s  mgmt;
    pasc_page_s  pg          = '0;
    logic        neg_restart = 1'b0;
    logic        pd_fault    = 1'b0;
    logic        an_able     = 1'b0;
    logic [15:0] rdata;
    logic        rvalid;
    wire  [3:0]  outs;
    logic        fsm_reset;
    int          bad_count   = 0;
    int          compares    = 0;
    logic [31:0] seed        = 32'h1E8ECE16;

    always #2 i_clk_sys = ~i_clk_sys;

    pasc_regs i_dut (
        .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_mgmt(mgmt),
        .o_rdata(rdata), .o_rvalid(rvalid), .i_page(pg),
        .i_neg_restart(neg_restart), .i_pd_fault(pd_fault),
        .i_partner_an_able(an_able), .o_force_link_100(outs[3]),
        .o_preamble_skip(outs[2]), .o_sleep(outs[1]),
        .o_remote_loopback(outs[0]), .o_fsm_reset(fsm_reset)
    );

    pasc_sme_model i_sme (
        .i_clk_sys(i_clk_sys), .i_rdata(rdata), .i_rvalid(rvalid), .o_mgmt(mgmt)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [15:0] exp_pa(input pasc_page_s p);
        return {p.next_page, p.ack, p.remote_fault, 3'h0, p.abilities, p.selector};
    endfunction

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rchk(input logic [4:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic        ok;
        i_sme.rd(a, d, ok);
        chk("read valid", 16'h0001, {15'h0000, ok});
        chk($sformatf("register %h", a), e, d);
    endtask

    task automatic ochk(input logic [3:0] e);
        repeat (2) @(posedge i_clk_sys);
        #1;
        chk("config outputs", {12'h000, e}, {12'h000, outs});
    endtask

    // Counts reset-pulse cycles in a window that starts at the write.
    task automatic rst_len(output int n);
        n = 0;
        #1;
        repeat (40) begin
            if (fsm_reset === 1'b1) n++;
            @(posedge i_clk_sys);
            #1;
        end
    endtask

    task automatic send(input pasc_page_s p);
        p.valid = 1'b1;
        repeat (2) begin
            @(posedge i_clk_sys);
            pg <= p;
        end
        @(posedge i_clk_sys);
        pg <= {1'b0, ~p[12:0]};
        repeat (3) @(posedge i_clk_sys);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge i_clk_sys);
        bad_count++;
        conclude();
    end

    initial begin
        pasc_page_s  p;
        logic [15:0] held;
        logic [15:0] d;
        int          n;
        repeat (4) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        rchk(ADDR_PARTNER, RESET_WORD);
        rchk(ADDR_EXPANSION, RESET_WORD);
        rchk(ADDR_CONFIG, RESET_WORD);
        rchk(5'h1F, 16'h0000);
        $display("test reset done");
        @(posedge i_clk_sys);
        an_able <= 1'b1;
        @(posedge i_clk_sys);
        an_able <= 1'b0;
        held = 16'h0000;
        p = '0;
        for (int k = 0; k < 4; k++) begin
            if (k != 3) begin
                seed = lfsr(seed);
                p = pasc_page_s'(seed[13:0]);
            end
            send(p);
            rchk(ADDR_PARTNER, exp_pa(p));
            d = {12'h000, p.next_page, LOCAL_LOCAL_NEXT_PAGE_CAPABLE, exp_pa(p) != held || k == 0, 1'b1};
            rchk(ADDR_EXPANSION, d);
            held = exp_pa(p);
            rchk(ADDR_EXPANSION, {12'h000, p.next_page, 3'b001});
        end
        @(posedge i_clk_sys);
        pg <= {1'b1, ~p[12:0]};
        @(posedge i_clk_sys);
        pg <= {1'b0, p[12:0]};
        rchk(ADDR_PARTNER, held);
        i_sme.wr(ADDR_PARTNER, 16'h23FF & ~held);
        rchk(ADDR_PARTNER, held);
        @(posedge i_clk_sys);
        neg_restart <= 1'b1;
        @(posedge i_clk_sys);
        neg_restart <= 1'b0;
        rchk(ADDR_PARTNER, 16'h0000);
        rchk(ADDR_EXPANSION, 16'h0000);
        @(posedge i_clk_sys);
        pd_fault <= 1'b1;
        @(posedge i_clk_sys);
        pd_fault <= 1'b0;
        rchk(ADDR_EXPANSION, 16'h0010);
        $display("test partner done");
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            d = (k == 0) ? 16'hFFF5 : (seed[15:0] & 16'hFFF5);
            i_sme.wr(ADDR_CONFIG, d);
            ochk({d[7], d[2], 1'b0, d[0]});
            rchk(ADDR_CONFIG, d & CFG_WRITE_MASK);
        end
        $display("test config done");
        i_sme.wr(ADDR_CONFIG, 16'h0008);
        rst_len(n);
        chk("reset length", 16'(FSM_RST_CYC), 16'(n));
        rchk(ADDR_CONFIG, 16'h0000);
        $display("test state reset done");
        i_sme.wr(ADDR_CONFIG, 16'h0087);
        ochk(4'hF);
        i_sme.wr(ADDR_CONFIG, 16'h0085);
        rst_len(n);
        chk("wake reset length", 16'(FSM_RST_CYC), 16'(n));
        chk("wake outputs", 16'h000D, {12'h000, outs});
        rchk(ADDR_CONFIG, 16'h0085);
        $display("test sleep done");
        conclude();
    end
endmodule
